// [verilog/srb_pkg.sv]
/*
 * shared constants of the sensor configuration block and its host controller:
 * register offsets, field positions, reset values and timing counts.
 * assumes a 125 MHz system clock and 16-bit link command words.
 */
package srb_pkg;
  // ==========================================================================
  // link command word
  localparam int unsigned WR_FLAG_BIT    = 15;
  localparam logic [7:0]  CFG_PAGE       = 8'h03;
  // ==========================================================================
  // byte offsets on the configuration page
  localparam logic [6:0]  PAGE_OFS       = 7'h00;
  localparam logic [6:0]  CMD_REG_OFS    = 7'h02;
  localparam logic [6:0]  SYNC_FN_OFS    = 7'h06;
  localparam logic [6:0]  MISC_OFS       = 7'h0a;
  localparam logic [6:0]  DEC_OFS        = 7'h0c;
  localparam logic [6:0]  BIAS_SETUP_OFS = 7'h0e;
  localparam logic [6:0]  SCALE_OFS      = 7'h10;
  localparam logic [6:0]  MODEL_OFS      = 7'h12;
  // ==========================================================================
  // reset values
  localparam logic [15:0] SYNC_FN_RST    = 16'h000d;
  localparam logic [15:0] MISC_RST       = 16'h00c0;
  localparam logic [15:0] DEC_RST        = 16'h0000;
  localparam logic [15:0] BIAS_SETUP_RST = 16'h070a;
  localparam logic [15:0] SCALE_RST      = 16'h109a;
  // ==========================================================================
  // field positions and limits
  localparam int unsigned MISC_GCOMP_BIT = 7;
  localparam int unsigned MISC_PERC_BIT  = 6;
  localparam int unsigned DEC_MSB        = 10;
  localparam logic [12:0] DEC_MAX        = 13'h1099;
  localparam int unsigned TB_MSB         = 3;
  localparam logic [3:0]  TB_MAX         = 4'hd;
  localparam int unsigned BIAS_EN_LSB    = 8;
  localparam int unsigned AVG_BASE_LOG2  = 6;
  localparam int unsigned FN_PPS_BIT     = 8;
  localparam int unsigned FN_SYNC_EN_BIT = 7;
  localparam int unsigned FN_SYNC_POL    = 6;
  localparam int unsigned FN_DRDY_EN_BIT = 3;
  localparam int unsigned FN_DRDY_POL    = 2;
  localparam int unsigned CMD_BIAS_BIT   = 0;
  localparam int unsigned FACTOR_FRAC    = 15;
  localparam int unsigned ACC_W          = 36;
  // ==========================================================================
  // timing
  localparam int unsigned CLK_HZ          = 125_000_000;
  localparam int unsigned INT_RATE_SPS    = 4250;
  localparam int unsigned INT_TICK_CYCLES = CLK_HZ / INT_RATE_SPS;
  localparam int unsigned PPS_MIN_HZ      = 1;
  localparam int unsigned PPS_MAX_HZ      = 128;
  localparam int unsigned PPS_MAX_PERIOD  = CLK_HZ / PPS_MIN_HZ;
  localparam int unsigned PPS_MIN_PERIOD  = (CLK_HZ + PPS_MAX_HZ - 1) / PPS_MAX_HZ;
  // ==========================================================================
  // host controller offsets
  localparam logic [3:0]  H_RAW_OFS      = 4'h0;
  localparam logic [3:0]  H_REGWR_OFS    = 4'h1;
  localparam logic [3:0]  H_RSP_OFS      = 4'h2;
  localparam logic [3:0]  H_SYNC_OFS     = 4'h3;
  localparam logic [3:0]  H_STAT_OFS     = 4'h4;

  typedef logic signed [15:0] srb_sample_t;
  typedef enum logic [1:0] {H_IDLE, H_PAGE, H_LO, H_HI} srb_hseq_e;
endpackage

// [verilog/srb_link_if.sv]
/*
 * link between the host controller and the sensor configuration block.
 * assumes both ends share clk; command words are single-cycle strobes.
 */
`timescale 1ns/1ps
interface srb_link_if (
  input logic clk
);
  logic        cmd_vld;
  logic [15:0] cmd_word;
  logic        rsp_vld;
  logic [15:0] rsp_word;
  logic        sync_line;
  logic        data_ready;

  modport dev  (input cmd_vld, cmd_word, sync_line, output rsp_vld, rsp_word, data_ready);
  modport host (output cmd_vld, cmd_word, sync_line, input rsp_vld, rsp_word, data_ready);
endinterface // srb_link_if

// [verilog/srb_axis_chan.sv]
/*
 * one sensor channel: window sum for the decimated delta output and the
 * long average that feeds the continuous bias estimator.
 * assumes tick is a one-cycle strobe and the end strobes come with a tick.
 */
`timescale 1ns/1ps
module srb_axis_chan
  import srb_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        tick,
  input  wire logic        dec_end,
  input  wire logic        avg_end,
  input  wire logic [4:0]  shift,
  input  wire srb_sample_t samp,
  output logic signed [31:0] delta_q,
  output srb_sample_t      est_q
);
  logic signed [ACC_W-1:0] dsum_q;
  logic signed [ACC_W-1:0] bsum_q;
  logic signed [ACC_W-1:0] dnext;
  logic signed [ACC_W-1:0] bnext;

  assign dnext = dsum_q + ACC_W'(samp);
  assign bnext = bsum_q + ACC_W'(samp);

  // ==========================================================================
  // decimation window
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dsum_q  <= '0;
      delta_q <= '0;
    end else if (tick) begin
      dsum_q <= dec_end ? '0 : dnext;
      if (dec_end) begin
        delta_q <= 32'(dnext);
      end
    end
  end

  // ==========================================================================
  // bias averaging window, 64 time bases long
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bsum_q <= '0;
      est_q  <= '0;
    end else if (tick) begin
      bsum_q <= avg_end ? '0 : bnext;
      if (avg_end) begin
        est_q <= 16'(bnext >>> shift);
      end
    end
  end
endmodule // srb_axis_chan

// [verilog/srb_sensor_dev.sv]
/*
 * sensor output-processing configuration: register page, sample clocking,
 * linear-g correction, decimation and continuous bias estimation.
 * assumes sensor samples are valid whenever a sample tick falls.
 */
// The address-and-strobe port was decided locally.
// Overview of operation
// - gyro plus factor matrix times accel, per sample
// - misc bit 7 switches gyro correction, default on
// - host clears bit 7 keeping percussion alignment set
// - final stage sums samples and extends delta window
// - output rate is sample rate over field+1
// - decimation field bits 10:0, max 4249, reset 0
// - byte write word: address with top bit, data
// - time base two to field over 4250, 64 bases
// - bits 13:8 enable gyro xyz then accel xyz
// - bias setup register resets to 0x070a
// - global command bit 0 loads enabled offsets
// - each enable rewrites both offset words of sensor
// - pps mode: rate is sync frequency times scale
// - host keeps sync between 1 Hz and 128 Hz
// - data ready still until one valid sync period
// - sync scale is 16 bits, reset 0x109a
// - host writes scale before enabling pps mode
// - read-only register low nibble gives model code
// - plain sync mode: each sync edge is a sample
// - misc bit 6 enables percussion alignment separately
`timescale 1ns/1ps
module srb_sensor_dev
  import srb_pkg::*;
#(
  parameter int unsigned INT_TICK   = INT_TICK_CYCLES,
  parameter int unsigned PPS_MIN    = PPS_MIN_PERIOD,
  parameter int unsigned PPS_MAX    = PPS_MAX_PERIOD,
  // arbitrary model code, not tied to any real part
  parameter logic [3:0]  MODEL_CODE = 4'h5
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  srb_link_if.dev          link,
  input  wire srb_sample_t accel_in         [3],
  input  wire srb_sample_t gyro_in          [3],
  input  wire srb_sample_t linear_accel_factor [9],
  output srb_sample_t      samp_q           [6],
  output logic signed [31:0] delta_q        [6],
  output logic             out_strobe_q,
  output logic signed [31:0] offset_q       [6],
  output logic             percussion_en_q
);
  logic [7:0]  page_q;
  logic [15:0] sync_fn_q;
  logic [15:0] misc_q;
  logic [15:0] dec_q;
  logic [15:0] bias_setup_q;
  logic [15:0] scale_q;
  logic        rsp_vld_q;
  logic [15:0] rsp_word_q;
  logic        drdy_q;
  logic        drdy_tog_q;
  logic        sync_prev_q;
  logic        edge_seen_q;
  logic        lock_q;
  logic [31:0] int_cnt_q;
  logic [31:0] per_cnt_q;
  logic [31:0] period_q;
  logic [32:0] acc_q;
  logic        tick;
  logic        tick_q;
  logic [10:0] dec_cnt_q;
  logic [18:0] avg_cnt_q;
  srb_sample_t est [6];
  logic signed [33:0] corr [3];

  // ==========================================================================
  // command decode
  function automatic logic hit(input logic [6:0] a, input logic [6:0] ofs);
    hit = (a[6:1] == ofs[6:1]);
  endfunction

  function automatic logic [15:0] put_byte(input logic [15:0] old, input logic hi,
                                           input logic [7:0] d);
    put_byte = hi ? {d, old[7:0]} : {old[15:8], d};
  endfunction

  logic       wr;
  logic       rd;
  logic       cfg_wr;
  logic [6:0] a;
  logic [7:0] d;
  logic       bias_cmd;

  assign wr       = link.cmd_vld && link.cmd_word[WR_FLAG_BIT];
  assign rd       = link.cmd_vld && !link.cmd_word[WR_FLAG_BIT];
  assign a        = link.cmd_word[14:8];
  assign d        = link.cmd_word[7:0];
  assign cfg_wr   = wr && (page_q == CFG_PAGE);
  assign bias_cmd = cfg_wr && (a == CMD_REG_OFS) && d[CMD_BIAS_BIT];

  // ==========================================================================
  // configuration registers, written one byte per command word
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      page_q       <= 8'h00;
      sync_fn_q    <= SYNC_FN_RST;
      misc_q       <= MISC_RST;
      dec_q        <= DEC_RST;
      bias_setup_q <= BIAS_SETUP_RST;
      scale_q      <= SCALE_RST;
    end else begin
      if (wr && a == PAGE_OFS) begin
        page_q <= d;
      end
      // model identifier has no write path here
      if (cfg_wr) begin
        if (hit(a, SYNC_FN_OFS))    sync_fn_q    <= put_byte(sync_fn_q, a[0], d);
        if (hit(a, MISC_OFS))       misc_q       <= put_byte(misc_q, a[0], d);
        if (hit(a, DEC_OFS))        dec_q        <= put_byte(dec_q, a[0], d);
        if (hit(a, BIAS_SETUP_OFS)) bias_setup_q <= put_byte(bias_setup_q, a[0], d);
        if (hit(a, SCALE_OFS))      scale_q      <= put_byte(scale_q, a[0], d);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      percussion_en_q <= 1'b0;
    end else begin
      percussion_en_q <= misc_q[MISC_PERC_BIT];
    end
  end

  // ==========================================================================
  // read answer one cycle after the read word
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rsp_vld_q  <= 1'b0;
      rsp_word_q <= 16'h0000;
    end else begin
      rsp_vld_q  <= rd;
      rsp_word_q <= 16'h0000;
      if (rd && hit(a, PAGE_OFS)) begin
        rsp_word_q <= {8'h00, page_q};
      end else if (rd && page_q == CFG_PAGE) begin
        if (hit(a, SYNC_FN_OFS))    rsp_word_q <= sync_fn_q;
        if (hit(a, MISC_OFS))       rsp_word_q <= misc_q;
        if (hit(a, DEC_OFS))        rsp_word_q <= dec_q;
        if (hit(a, BIAS_SETUP_OFS)) rsp_word_q <= bias_setup_q;
        if (hit(a, SCALE_OFS))      rsp_word_q <= scale_q;
        if (hit(a, MODEL_OFS))      rsp_word_q <= {12'h000, MODEL_CODE};
      end
    end
  end

  assign link.rsp_vld    = rsp_vld_q;
  assign link.rsp_word   = rsp_word_q;
  assign link.data_ready = drdy_q;

  // ==========================================================================
  // sample clock: internal, sync edges or scaled pps
  logic sync_en;
  logic pulse_per_second_mode;
  logic sync_edge;
  logic per_ok;

  assign sync_en   = sync_fn_q[FN_SYNC_EN_BIT];
  assign pulse_per_second_mode       = sync_fn_q[FN_PPS_BIT];
  assign sync_edge = sync_fn_q[FN_SYNC_POL] ? (link.sync_line && !sync_prev_q)
                                            : (!link.sync_line && sync_prev_q);
  assign per_ok    = (per_cnt_q >= PPS_MIN) && (per_cnt_q <= PPS_MAX);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync_prev_q <= 1'b0;
      int_cnt_q   <= '0;
    end else begin
      sync_prev_q <= link.sync_line;
      int_cnt_q   <= (int_cnt_q >= INT_TICK - 1) ? '0 : int_cnt_q + 32'h1;
    end
  end

  // period of the sync input; a bad period drops the lock
  always_ff @(posedge clk) begin
    if (sys_rst || !(sync_en && pulse_per_second_mode)) begin
      per_cnt_q   <= '0;
      period_q    <= '0;
      edge_seen_q <= 1'b0;
      lock_q      <= 1'b0;
    end else if (sync_edge) begin
      per_cnt_q   <= 32'h1;
      edge_seen_q <= 1'b1;
      lock_q      <= edge_seen_q && per_ok;
      if (per_ok) begin
        period_q <= per_cnt_q;
      end
    end else if (per_cnt_q <= PPS_MAX) begin
      per_cnt_q <= per_cnt_q + 32'h1;
    end
  end

  // rate = scale / period per clock, so sync frequency times scale
  // a product above the clock rate caps at one tick per cycle
  logic [32:0] acc_sum;
  assign acc_sum = acc_q + 33'(scale_q);

  always_ff @(posedge clk) begin
    if (sys_rst || !lock_q) begin
      acc_q <= '0;
    end else begin
      acc_q <= (acc_sum >= 33'(period_q)) ? acc_sum - 33'(period_q) : acc_sum;
    end
  end

  always_comb begin
    if (!sync_en) begin
      tick = (int_cnt_q == 32'h0);
    end else if (!pulse_per_second_mode) begin
      tick = sync_edge;
    end else begin
      tick = lock_q && (acc_sum >= 33'(period_q)) && (scale_q != 16'h0000);
    end
  end

  // ==========================================================================
  // linear-g correction; factors are signed with 15 fraction bits
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      corr[i] = '0;
      for (int j = 0; j < 3; j++) begin
        corr[i] = corr[i] + 34'(linear_accel_factor[3*i+j] * accel_in[j]);
      end
    end
  end

  // no saturation: a correction past full scale wraps
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tick_q <= 1'b0;
      for (int i = 0; i < 6; i++) samp_q[i] <= '0;
    end else begin
      tick_q <= tick;
      if (tick) begin
        for (int i = 0; i < 3; i++) begin
          samp_q[i]   <= misc_q[MISC_GCOMP_BIT] ?
                         gyro_in[i] + 16'(corr[i] >>> FACTOR_FRAC) : gyro_in[i];
          samp_q[i+3] <= accel_in[i];
        end
      end
    end
  end

  // ==========================================================================
  // decimation and averaging windows
  logic [10:0] dec_lim;
  logic [3:0]  tb_sel;
  logic        dec_end;
  logic        avg_end;

  // an 11-bit field cannot pass the limit; the compare keeps it explicit
  assign dec_lim = ({2'b00, dec_q[DEC_MSB:0]} > DEC_MAX) ? 11'(DEC_MAX)
                                                         : dec_q[DEC_MSB:0];
  assign tb_sel  = (bias_setup_q[TB_MSB:0] > TB_MAX) ? TB_MAX : bias_setup_q[TB_MSB:0];
  assign dec_end = (dec_cnt_q >= dec_lim);
  assign avg_end = (avg_cnt_q >= 19'((20'h1 << (AVG_BASE_LOG2 + tb_sel)) - 20'h1));

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dec_cnt_q    <= '0;
      avg_cnt_q    <= '0;
      out_strobe_q <= 1'b0;
      drdy_tog_q   <= 1'b0;
    end else begin
      out_strobe_q <= tick_q && dec_end;
      if (tick_q) begin
        dec_cnt_q <= dec_end ? '0 : dec_cnt_q + 11'h1;
        avg_cnt_q <= avg_end ? '0 : avg_cnt_q + 19'h1;
        if (dec_end) drdy_tog_q <= !drdy_tog_q;
      end
    end
  end

  // idle level is the inactive level of the chosen polarity
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      drdy_q <= 1'b0;
    end else if (sync_fn_q[FN_DRDY_EN_BIT] && (!(sync_en && pulse_per_second_mode) || lock_q)) begin
      drdy_q <= drdy_tog_q ^ !sync_fn_q[FN_DRDY_POL];
    end else begin
      drdy_q <= !sync_fn_q[FN_DRDY_POL];
    end
  end

  for (genvar g = 0; g < 6; g++) begin : g_chan
    srb_axis_chan u_chan (
      .clk     (clk),
      .sys_rst (sys_rst),
      .tick    (tick_q),
      .dec_end (dec_end),
      .avg_end (avg_end),
      .shift   (5'(AVG_BASE_LOG2 + tb_sel)),
      .samp    (samp_q[g]),
      .delta_q (delta_q[g]),
      .est_q   (est[g])
    );
  end

  // ==========================================================================
  // bias update command: offset cancels the present estimate
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 6; i++) offset_q[i] <= '0;
    end else if (bias_cmd) begin
      for (int i = 0; i < 6; i++) begin
        if (bias_setup_q[BIAS_EN_LSB+i]) begin
          offset_q[i] <= -32'(est[i]);
        end
      end
    end
  end
endmodule // srb_sensor_dev

// [verilog/srb_host_ctl.sv]
/*
 * host end: turns software register writes into link command words,
 * keeps the last read answer and generates the sync input.
 * assumes software polls the busy bit before a new command.
 */
`timescale 1ns/1ps
module srb_host_ctl
  import srb_pkg::*;
#(
  parameter int unsigned HALF_MIN = PPS_MIN_PERIOD / 2,
  parameter int unsigned HALF_MAX = PPS_MAX_PERIOD / 2
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  srb_link_if.host         link,
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic [31:0]      rdata_q
);
  srb_hseq_e   seq_q;
  logic [6:0]  reg_a_q;
  logic [15:0] reg_v_q;
  logic        cmd_vld_q;
  logic [15:0] cmd_word_q;
  logic [15:0] rsp_q;
  logic        rsp_new_q;
  logic [31:0] half_q;
  logic [31:0] sync_cnt_q;
  logic        sync_q;
  logic        busy;

  assign busy = (seq_q != H_IDLE);

  // ==========================================================================
  // command sequencer: page select, low byte, then high byte
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      seq_q      <= H_IDLE;
      reg_a_q    <= '0;
      reg_v_q    <= '0;
      cmd_vld_q  <= 1'b0;
      cmd_word_q <= 16'h0000;
    end else begin
      cmd_vld_q <= 1'b0;
      unique case (seq_q)
        H_IDLE: begin
          if (wr_en && addr == H_RAW_OFS) begin
            cmd_vld_q  <= 1'b1;
            cmd_word_q <= wdata[15:0];
          end else if (wr_en && addr == H_REGWR_OFS) begin
            reg_a_q <= {wdata[22:17], 1'b0};
            reg_v_q <= wdata[15:0];
            seq_q   <= H_PAGE;
          end
        end
        H_PAGE: begin
          cmd_vld_q  <= 1'b1;
          cmd_word_q <= {1'b1, PAGE_OFS, CFG_PAGE};
          seq_q      <= H_LO;
        end
        H_LO: begin
          cmd_vld_q  <= 1'b1;
          cmd_word_q <= {1'b1, reg_a_q, reg_v_q[7:0]};
          seq_q      <= H_HI;
        end
        H_HI: begin
          cmd_vld_q  <= 1'b1;
          cmd_word_q <= {1'b1, reg_a_q | 7'h01, reg_v_q[15:8]};
          seq_q      <= H_IDLE;
        end
      endcase
    end
  end

  assign link.cmd_vld  = cmd_vld_q;
  assign link.cmd_word = cmd_word_q;

  // ==========================================================================
  // answers; a new answer beats a read that clears the flag
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rsp_q     <= 16'h0000;
      rsp_new_q <= 1'b0;
    end else if (link.rsp_vld) begin
      rsp_q     <= link.rsp_word;
      rsp_new_q <= 1'b1;
    end else if (rd_en && addr == H_RSP_OFS) begin
      rsp_new_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= 32'h0000_0000;
      if (rd_en) begin
        unique case (addr)
          H_RSP_OFS:  rdata_q <= {15'h0000, rsp_new_q, rsp_q};
          H_SYNC_OFS: rdata_q <= half_q;
          H_STAT_OFS: rdata_q <= {30'h0000_0000, link.data_ready, busy};
          default:    rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ==========================================================================
  // sync generator; half period clamped to the 1 Hz to 128 Hz band
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      half_q <= '0;
    end else if (wr_en && addr == H_SYNC_OFS) begin
      if (wdata == 32'h0)         half_q <= '0;
      else if (wdata < HALF_MIN)  half_q <= HALF_MIN;
      else if (wdata > HALF_MAX)  half_q <= HALF_MAX;
      else                        half_q <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || half_q == 32'h0) begin
      sync_cnt_q <= '0;
      sync_q     <= 1'b0;
    end else if (sync_cnt_q >= half_q - 32'h1) begin
      sync_cnt_q <= '0;
      sync_q     <= !sync_q;
    end else begin
      sync_cnt_q <= sync_cnt_q + 32'h1;
    end
  end

  assign link.sync_line = sync_q;
endmodule // srb_host_ctl

// [testbench/srb_link_assertions.sv]
/*
 * link checker: answers to read words and register contents on the config page.
 * assumes both ends share clk and that sys_rst is synchronous, active high.
 */
`timescale 1ns/1ps
module srb_link_assertions
  import srb_pkg::*;
#(
  parameter logic [3:0] MODEL_CODE = 4'h5
) (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        cmd_vld,
  input wire logic [15:0] cmd_word,
  input wire logic        rsp_vld,
  input wire logic [15:0] rsp_word
);
  // ==========================================================================
  // shadow of page select and bytes 0x0c..0x11, kept from the write words
  logic [7:0] page_q;
  logic [7:0] sh_q [6];
  logic       rd_c;
  logic [6:0] ad_c;
  assign rd_c = cmd_vld && !cmd_word[WR_FLAG_BIT];
  assign ad_c = cmd_word[14:8];
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      page_q <= 8'h00;
      sh_q   <= '{8'h00, 8'h00, 8'h0a, 8'h07, 8'h9a, 8'h10};
    end else if (cmd_vld && cmd_word[WR_FLAG_BIT]) begin
      if (ad_c == PAGE_OFS) page_q <= cmd_word[7:0];
      else if (page_q == CFG_PAGE && ad_c >= DEC_OFS && ad_c < MODEL_OFS)
        sh_q[3'(ad_c - DEC_OFS)] <= cmd_word[7:0];
    end
  end
  // ==========================================================================
  // properties
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_read_answer: assert property (rd_c |=> rsp_vld)
    else $error("read word got no answer");
  a_answer_cause: assert property (rsp_vld |-> $past(rd_c))
    else $error("answer without a read word");
  a_idle_zero: assert property (!rsp_vld |-> rsp_word == 16'h0000)
    else $error("answer word not zero when idle");
  a_page_gate: assert property (
    rd_c && page_q != CFG_PAGE && ad_c[6:1] != 6'h00 |=> rsp_word == 16'h0000)
    else $error("register seen off its page");
  a_dec_value: assert property (
    rd_c && page_q == CFG_PAGE && ad_c == DEC_OFS |=> rsp_word == {sh_q[1], sh_q[0]})
    else $error("decimation value wrong");
  a_bias_value: assert property (
    rd_c && page_q == CFG_PAGE && ad_c == BIAS_SETUP_OFS |=> rsp_word == {sh_q[3], sh_q[2]})
    else $error("bias setup value wrong");
  a_scale_value: assert property (
    rd_c && page_q == CFG_PAGE && ad_c == SCALE_OFS |=> rsp_word == {sh_q[5], sh_q[4]})
    else $error("sync scale value wrong");
  a_model_code: assert property (
    rd_c && page_q == CFG_PAGE && ad_c == MODEL_OFS |=> rsp_word[3:0] == MODEL_CODE)
    else $error("model code changed");
endmodule // srb_link_assertions

// [testbench/sample_rate_bias_config_bench.sv]
/*
 * bench: host controller and sensor block joined by the link, driven through
 * the host user port. assumes short tick and pps parameters as set below.
 */
`timescale 1ns/1ps
module sample_rate_bias_config_bench
  import srb_pkg::*;
;
  logic        clk;
  logic        sys_rst;
  logic [3:0]  addr;
  logic [31:0] wdata;
  logic        wr_en;
  logic        rd_en;
  logic [31:0] rdata_q;
  srb_sample_t accel_in [3];
  srb_sample_t gyro_in [3];
  srb_sample_t factor [9];
  srb_sample_t samp_q [6];
  logic signed [31:0] delta_q [6];
  logic signed [31:0] offset_q [6];
  logic        perc;
  logic        out_strobe_q;
  int          n_fail;
  int          checked;
  int          n;
  int          n_strb = 0;
  logic [31:0] v;
  // ==========================================================================
  // structure
  srb_link_if u_link (.clk(clk));
  srb_sensor_dev #(.INT_TICK(20), .PPS_MIN(50), .PPS_MAX(400)) u_srb_sensor_dev (
    .clk(clk), .sys_rst(sys_rst), .link(u_link), .accel_in(accel_in), .gyro_in(gyro_in),
    .linear_accel_factor(factor), .samp_q(samp_q), .delta_q(delta_q),
    .out_strobe_q(out_strobe_q), .offset_q(offset_q), .percussion_en_q(perc));
  srb_host_ctl #(.HALF_MIN(25), .HALF_MAX(200)) u_srb_host_ctl (
    .clk(clk), .sys_rst(sys_rst), .link(u_link), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata_q(rdata_q));
  srb_link_assertions u_srb_link_assertions (
    .clk(clk), .sys_rst(sys_rst), .cmd_vld(u_link.cmd_vld), .cmd_word(u_link.cmd_word),
    .rsp_vld(u_link.rsp_vld), .rsp_word(u_link.rsp_word));
  // output strobes, counted for the rate check
  always @(posedge clk) n_strb <= n_strb + int'(out_strobe_q === 1'b1);
  // ==========================================================================
  // tasks
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic hw(logic [3:0] a, logic [31:0] d);
    @(posedge clk) begin addr <= a; wdata <= d; wr_en <= 1'b1; end
    @(posedge clk) wr_en <= 1'b0;
  endtask
  task automatic hr(logic [3:0] a, output logic [31:0] v);
    @(posedge clk) begin addr <= a; rd_en <= 1'b1; end
    @(posedge clk) rd_en <= 1'b0;
    #1 v = rdata_q;
  endtask
  // regwr words land at +2..+4, so five edges clear the busy span
  task automatic regwr(logic [6:0] a, logic [15:0] v);
    hw(H_REGWR_OFS, {9'h000, a, v});
    repeat (5) @(posedge clk);
  endtask
  task automatic devrd(string nm, logic [6:0] a, logic [15:0] e, logic [15:0] m);
    logic [31:0] v;
    hw(H_RAW_OFS, {16'h0000, 1'b0, a, 8'h00});
    repeat (3) @(posedge clk);
    hr(H_RSP_OFS, v);
    chk(nm, {1'b1, e & m}, {v[16], v[15:0] & m});
  endtask
  task automatic tog(output int c);
    logic l;
    l = u_link.data_ready;
    c = 0;
    do begin @(posedge clk); #1 c++; end while (u_link.data_ready === l && c < 2000);
  endtask
  task automatic complete_run();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========================================================================
  // clock, watchdog, tests
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    complete_run();
  end
  initial begin
    sys_rst = 1'b1; addr = 4'h0; wdata = 32'h0; wr_en = 1'b0; rd_en = 1'b0;
    n_fail = 0; checked = 0;
    accel_in = '{16'sh0064, 16'sh0000, 16'sh0000};
    gyro_in = '{16'sh0028, 16'sh0000, 16'sh0000};
    factor = '{16'sh4000, 16'sh0, 16'sh0, 16'sh0, 16'sh0, 16'sh0, 16'sh0, 16'sh0, 16'sh0};
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    hw(H_RAW_OFS, 32'h0000_8003);
    devrd("dec", DEC_OFS, 16'h0000, 16'hffff);
    devrd("bias", BIAS_SETUP_OFS, 16'h070a, 16'hffff);
    devrd("scale", SCALE_OFS, 16'h109a, 16'hffff);
    devrd("misc", MISC_OFS, 16'h00c0, 16'hffff);
    devrd("model", MODEL_OFS, 16'h0005, 16'h000f);
    repeat (50) @(posedge clk);
    chk("gyro corrected", 32'h005a, 32'(samp_q[0]));
    regwr(MISC_OFS, 16'h0040);
    devrd("misc", MISC_OFS, 16'h0040, 16'hffff);
    chk("percussion", 32'h1, {31'h0, perc});
    repeat (50) @(posedge clk);
    chk("gyro plain", 32'h0028, 32'(samp_q[0]));
    regwr(DEC_OFS, 16'h002a);
    devrd("dec", DEC_OFS, 16'h002a, 16'hffff);
    tog(n);
    tog(n);
    tog(n);
    chk("ready period", 32'd860, 32'(n));
    chk("delta gx", 32'd1720, delta_q[0]);
    regwr(SCALE_OFS, 16'h0fa0);
    devrd("scale", SCALE_OFS, 16'h0fa0, 16'hffff);
    regwr(MODEL_OFS, 16'hffff);
    devrd("model", MODEL_OFS, 16'h0005, 16'h000f);
    regwr(BIAS_SETUP_OFS, 16'h0100);
    devrd("bias", BIAS_SETUP_OFS, 16'h0100, 16'hffff);
    repeat (2700) @(posedge clk);
    regwr(CMD_REG_OFS, 16'h0001);
    repeat (10) @(posedge clk);
    chk("offset gx", 32'hffffffd8, offset_q[0]);
    chk("offset gy", 32'h0, offset_q[1]);
    regwr(DEC_OFS, 16'h0000);
    regwr(SCALE_OFS, 16'h0002);
    hw(H_SYNC_OFS, 32'd5000);
    hr(H_SYNC_OFS, v);
    chk("sync clamp", 32'd200, v);
    hw(H_SYNC_OFS, 32'd50);
    regwr(SYNC_FN_OFS, 16'h00cd);
    tog(n);
    tog(n);
    tog(n);
    chk("sync period", 32'd100, 32'(n));
    regwr(SYNC_FN_OFS, 16'h01cd);
    hr(H_STAT_OFS, v);
    chk("ready held", 32'h0, {31'h0, v[1]});
    tog(n);
    tog(n);
    tog(n);
    chk("pps period", 32'd50, 32'(n));
    n = n_strb;
    repeat (500) @(posedge clk);
    #1 chk("strobes", 32'd10, 32'(n_strb - n));
    complete_run();
  end
endmodule // sample_rate_bias_config_bench
